// File: src/pic_top.v
// Contract
// - A read of a status register shows one for each posted source.
// - With soft posting off, a written zero clears that posted bit.
// - Clearing a bit that is not posted changes no interrupt state.
// - With soft posting off, a written one leaves that bit alone.
// - With soft posting on, a written zero has no effect.
// - With soft posting on, a written one posts as the source would.
// - Group a holds bus slave 7, sleep 6, SPI 5, pins 4, timer 3, supply 0.
// - Group b holds endpoints 3..0 on 7..4, frame 3, reset 2, timers 1, 0.
// - Group c holds wake on 5 and endpoints 8..4 on 4..0.
// - One enable bit picks clear-on-zero or post-on-one behaviour.
// - A masked source still posts; the mask only gates pending.
// - Any vector clear write clears every posted interrupt.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps
`include "pic_map.vh"
module pic_top
(
    input wire hclk,                // System clock, 20 MHz
    input wire hresetn,             // Async reset, active low
    input wire hsel,                // AHB slave select
    input wire [31:0] haddr,        // AHB address
    input wire [1:0] htrans,        // AHB transfer type
    input wire hwrite,              // AHB write
    input wire [2:0] hsize,         // AHB size
    input wire [31:0] hwdata,       // AHB write data
    input wire hready,              // AHB ready in
    output wire hreadyout,          // AHB ready out
    output wire hresp,              // AHB response
    output wire [31:0] hrdata,      // AHB read data
    input wire sbus_slave_evt,      // Serial bus slave event
    input wire sleep_evt,           // Sleep timer event
    input wire spi_evt,             // SPI event
    input wire gpio_evt,            // General pin event
    input wire timer_zero_irq,      // Timer zero event
    input wire supply_mon_evt,      // Supply monitor event
    input wire timer_one_irq,       // Timer one event
    input wire timer_two_irq,       // Timer two event
    input wire usb_reset_evt,       // USB bus reset event
    input wire usb_sof_evt,         // USB start of frame event
    input wire [8:0] usb_ep_evt,    // USB endpoint events
    input wire usb_wake_evt,        // USB wake event
    input wire [23:0] ack_clr,      // Acknowledge clears {c,b,a}
    output reg irq_pending,         // Unmasked posted source
    output wire [23:0] posted_vec,  // Posted state {c,b,a}
    output wire soft_irq_enable,    // Soft posting mode
    output wire evt_irq             // Block event interrupt
);

    wire reg_wr;
    wire reg_rd;
    wire [7:0] reg_idx;
    wire [7:0] reg_wdata;
    reg [7:0] reg_rdata;

    wire [7:0] set_a;
    wire [7:0] set_b;
    wire [7:0] set_c;
    wire [7:0] posted_a;
    wire [7:0] posted_b;
    wire [7:0] posted_c;

    reg [7:0] irq_mask_a_q;
    reg [7:0] irq_mask_b_q;
    reg [7:0] irq_mask_c_q;
    reg soft_irq_enable_q;
    reg [2:0] evt_status_q;
    reg [2:0] evt_mask_q;
    reg [2:0] evt_set;

    wire wr_status_a;
    wire wr_status_b;
    wire wr_status_c;
    wire clr_all;
    wire [23:0] hw_set_all;
    wire [23:0] posted_all;
    wire [23:0] soft_data;
    wire [23:0] mask_all;
    wire [2:0] grp_pend;

    function sel;
        input [7:0] idx;
        input [7:0] target;
        begin
            sel = (idx == target);
        end
    endfunction

    pic_ahb_slave u_bus
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_idx(reg_idx),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata)
    );

    // Source bit placement
    assign set_a = {sbus_slave_evt, sleep_evt, spi_evt, gpio_evt,
        timer_zero_irq, 2'h0, supply_mon_evt};
    assign set_b = {usb_ep_evt[3:0], usb_sof_evt, usb_reset_evt,
        timer_two_irq, timer_one_irq};
    assign set_c = {2'h0, usb_wake_evt, usb_ep_evt[8:4]};

    assign wr_status_a = reg_wr & sel(reg_idx, `PIC_IDX_STATUS_A);
    assign wr_status_b = reg_wr & sel(reg_idx, `PIC_IDX_STATUS_B);
    assign wr_status_c = reg_wr & sel(reg_idx, `PIC_IDX_STATUS_C);
    assign clr_all = reg_wr & sel(reg_idx, `PIC_IDX_VEC_CLR);

    // Reserved positions are dropped inside the banks, so a stray
    // one written there by firmware cannot post a phantom source
    pic_post_bank #(.IMPL(`PIC_IMPL_A)) u_bank_a
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .hw_set(set_a),
        .ack_clr(ack_clr[7:0]),
        .wr_en(wr_status_a),
        .wr_data(reg_wdata),
        .soft_en(soft_irq_enable_q),
        .clr_all(clr_all),
        .posted(posted_a)
    );

    pic_post_bank #(.IMPL(`PIC_IMPL_B)) u_bank_b
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .hw_set(set_b),
        .ack_clr(ack_clr[15:8]),
        .wr_en(wr_status_b),
        .wr_data(reg_wdata),
        .soft_en(soft_irq_enable_q),
        .clr_all(clr_all),
        .posted(posted_b)
    );

    pic_post_bank #(.IMPL(`PIC_IMPL_C)) u_bank_c
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .hw_set(set_c),
        .ack_clr(ack_clr[23:16]),
        .wr_en(wr_status_c),
        .wr_data(reg_wdata),
        .soft_en(soft_irq_enable_q),
        .clr_all(clr_all),
        .posted(posted_c)
    );

    assign posted_all = {posted_c, posted_b, posted_a};
    assign hw_set_all = {set_c & `PIC_IMPL_C, set_b & `PIC_IMPL_B,
        set_a & `PIC_IMPL_A};
    assign soft_data = {
        wr_status_c ? reg_wdata & `PIC_IMPL_C : 8'h00,
        wr_status_b ? reg_wdata & `PIC_IMPL_B : 8'h00,
        wr_status_a ? reg_wdata & `PIC_IMPL_A : 8'h00};
    assign posted_vec = posted_all;

    // Mask, mode and event mask registers
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_mask_a_q <= `PIC_RST_BYTE;
            irq_mask_b_q <= `PIC_RST_BYTE;
            irq_mask_c_q <= `PIC_RST_BYTE;
            soft_irq_enable_q <= 1'b0;
            evt_mask_q <= `PIC_RST_EVT;
        end
        else if (reg_wr)
        begin
            if (sel(reg_idx, `PIC_IDX_MASK_A))
                irq_mask_a_q <= reg_wdata & `PIC_IMPL_A;
            if (sel(reg_idx, `PIC_IDX_MASK_B))
                irq_mask_b_q <= reg_wdata & `PIC_IMPL_B;
            if (sel(reg_idx, `PIC_IDX_MASK_C))
                irq_mask_c_q <= reg_wdata & `PIC_IMPL_C;
            if (sel(reg_idx, `PIC_IDX_SOFT_CTRL))
                soft_irq_enable_q <= reg_wdata[`PIC_SOFT_EN_BIT];
            if (sel(reg_idx, `PIC_IDX_EVT_MASK))
                evt_mask_q <= reg_wdata[2:0] & `PIC_EVT_IMPL;
        end
    end

    assign soft_irq_enable = soft_irq_enable_q;

    assign mask_all = {irq_mask_c_q, irq_mask_b_q, irq_mask_a_q};

    // Mask only gates the pending output, posting goes on regardless
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_pend
            assign grp_pend[g] = |(posted_all[8*g+7:8*g]
                & mask_all[8*g+7:8*g]);
        end
    endgenerate

    // Vector clear drops pending at once instead of a cycle late
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_pending <= 1'b0;
        else if (clr_all)
            irq_pending <= 1'b0;
        else
            irq_pending <= |grp_pend;
    end

    // Block events: new source post, software post, source post onto a
    // bit already set (the second event is merged and lost)
    always @*
    begin
        evt_set = 3'h0;
        evt_set[`PIC_EVT_HW_POST] = |(hw_set_all & ~posted_all);
        evt_set[`PIC_EVT_SOFT_POST] = soft_irq_enable_q & |soft_data;
        evt_set[`PIC_EVT_OVERRUN] = |(hw_set_all & posted_all);
    end

    // Write one to clear; a new event in the same cycle stays set
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            evt_status_q <= `PIC_RST_EVT;
        else if (reg_wr & sel(reg_idx, `PIC_IDX_EVT_STATUS))
            evt_status_q <= (evt_status_q & ~reg_wdata[2:0]) | evt_set;
        else
            evt_status_q <= evt_status_q | evt_set;
    end

    assign evt_irq = |(evt_status_q & evt_mask_q);

    // Read data; vector clear reads as zero as vectoring lives elsewhere
    always @*
    begin
        reg_rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_idx)
                `PIC_IDX_STATUS_A: reg_rdata = posted_a;
                `PIC_IDX_STATUS_B: reg_rdata = posted_b;
                `PIC_IDX_STATUS_C: reg_rdata = posted_c;
                `PIC_IDX_MASK_A: reg_rdata = irq_mask_a_q;
                `PIC_IDX_MASK_B: reg_rdata = irq_mask_b_q;
                `PIC_IDX_MASK_C: reg_rdata = irq_mask_c_q;
                `PIC_IDX_SOFT_CTRL: reg_rdata = {7'h00, soft_irq_enable_q};
                `PIC_IDX_EVT_STATUS: reg_rdata = {5'h00, evt_status_q};
                `PIC_IDX_EVT_MASK: reg_rdata = {5'h00, evt_mask_q};
                default: reg_rdata = 8'h00;
            endcase
        end
    end

endmodule

// File: src/pic_map.vh
`ifndef PIC_MAP_VH
`define PIC_MAP_VH

// Register indices; byte address is four times the index
`define PIC_IDX_STATUS_A 8'hDA
`define PIC_IDX_STATUS_B 8'hDB
`define PIC_IDX_STATUS_C 8'hDC
`define PIC_IDX_MASK_C 8'hDE
`define PIC_IDX_MASK_B 8'hDF
`define PIC_IDX_MASK_A 8'hE0
`define PIC_IDX_SOFT_CTRL 8'hE1
`define PIC_IDX_VEC_CLR 8'hE2
`define PIC_IDX_EVT_STATUS 8'hF0
`define PIC_IDX_EVT_MASK 8'hF1

// Implemented bits of each posted group
`define PIC_IMPL_A 8'hF9
`define PIC_IMPL_B 8'hFF
`define PIC_IMPL_C 8'h3F

// Field positions
`define PIC_SOFT_EN_BIT 0
`define PIC_EVT_HW_POST 0
`define PIC_EVT_SOFT_POST 1
`define PIC_EVT_OVERRUN 2
`define PIC_EVT_IMPL 3'h7

// Reset values
`define PIC_RST_BYTE 8'h00
`define PIC_RST_EVT 3'h0

`endif

// File: src/pic_post_bank.v
`timescale 1ns/10ps
module pic_post_bank
#(
    parameter [7:0] IMPL = 8'hFF
)
(
    input wire hclk,                // System clock
    input wire hresetn,             // Async reset, active low
    input wire [7:0] hw_set,        // Source event pulses
    input wire [7:0] ack_clr,       // Clear on acknowledge
    input wire wr_en,               // Firmware write strobe
    input wire [7:0] wr_data,       // Firmware write data
    input wire soft_en,             // Software post mode
    input wire clr_all,             // Vector clear write
    output wire [7:0] posted        // Posted state
);

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_bit
            wire sw_set;
            wire sw_clr;
            reg bit_q;
            // Post on one only in software mode
            assign sw_set = wr_en & soft_en & wr_data[i];
            // Clear on zero only with software mode off
            assign sw_clr = (wr_en & ~soft_en & ~wr_data[i])
                | clr_all | ack_clr[i];
            // Each bit owns its flop, so no vector has several drivers
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    bit_q <= 1'b0;
                else if (!IMPL[i])
                    bit_q <= 1'b0;
                else if (hw_set[i] | sw_set)
                    bit_q <= 1'b1;
                else if (sw_clr)
                    bit_q <= 1'b0;
            end
            assign posted[i] = bit_q;
        end
    endgenerate

endmodule

// File: src/pic_ahb_slave.v
`timescale 1ns/10ps
module pic_ahb_slave
(
    input wire hclk,                // System clock
    input wire hresetn,             // Async reset, active low
    input wire hsel,                // Slave select
    input wire [31:0] haddr,        // Byte address
    input wire [1:0] htrans,        // Transfer type
    input wire hwrite,              // Write when high
    input wire [2:0] hsize,         // Transfer size
    input wire [31:0] hwdata,       // Write data
    input wire hready,              // Bus ready
    output wire hreadyout,          // Slave ready
    output wire hresp,              // Always OKAY
    output reg [31:0] hrdata,       // Read data
    output wire reg_wr,             // Register write pulse
    output wire reg_rd,             // Register read pulse
    output wire [7:0] reg_idx,      // Register index
    output wire [7:0] reg_wdata,    // Register write byte
    input wire [7:0] reg_rdata      // Register read byte
);

    reg ph_wr_q;
    reg ph_rd_q;
    reg rd_done_q;
    reg ok_q;
    reg [7:0] idx_q;
    wire take;
    wire mapped;

    assign take = hsel & htrans[1] & hready;
    // Whole aligned words inside the block's 1 KB window only
    assign mapped = (haddr[31:10] == 22'h000000) &
        (haddr[1:0] == 2'h0) & (hsize == 3'h2);

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_wr_q <= 1'b0;
            ph_rd_q <= 1'b0;
            rd_done_q <= 1'b0;
            ok_q <= 1'b0;
            idx_q <= 8'h00;
            hrdata <= 32'h00000000;
        end
        else
        begin
            rd_done_q <= ph_rd_q & ~rd_done_q;
            if (take)
            begin
                ph_wr_q <= hwrite;
                ph_rd_q <= ~hwrite;
                ok_q <= mapped;
                idx_q <= haddr[9:2];
            end
            else if (hreadyout)
            begin
                ph_wr_q <= 1'b0;
                ph_rd_q <= 1'b0;
            end
            // One wait state so read data comes from a flop
            if (ph_rd_q & ~rd_done_q)
                hrdata <= {24'h000000, ok_q ? reg_rdata : 8'h00};
        end
    end

    assign hreadyout = ~(ph_rd_q & ~rd_done_q);
    assign hresp = 1'b0;
    assign reg_wr = ph_wr_q & ok_q;
    assign reg_rd = ph_rd_q & ~rd_done_q & ok_q;
    assign reg_idx = idx_q;
    assign reg_wdata = hwdata[7:0];

endmodule

// File: testbench/pic_top_asserts.sv
`timescale 1ns/10ps
module pic_top_asserts
(
    input wire hclk,              // Clock
    input wire hresetn,           // Reset, active low
    input wire hsel,              // Select
    input wire [1:0] htrans,      // Transfer type
    input wire hwrite,            // Write
    input wire hready,            // Ready in
    input wire hreadyout,         // Ready out
    input wire hresp,             // Response
    input wire spi_evt,           // SPI source
    input wire usb_wake_evt,      // Wake source
    input wire [23:0] ack_clr,    // Acknowledge clears
    input wire irq_pending,       // Pending
    input wire [23:0] posted_vec, // Posted state
    input wire soft_irq_enable    // Soft mode
);
    reg wr_q;
    reg any_q;
    wire take = hsel & htrans[1] & hready;
    // What the last edge saw, to judge the edge after it
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            any_q <= 1'b0;
        end
        else
        begin
            wr_q <= take & hwrite;
            any_q <= |posted_vec;
        end
    end
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_spi_posts: assert property (spi_evt |=> posted_vec[5])
        else $error("spi event not posted");
    a_wake_posts: assert property (
        usb_wake_evt |-> ##1 posted_vec[21])
        else $error("wake event not posted");
    a_resv_zero: assert property (
        posted_vec[2:1] == 2'h0 && posted_vec[23:22] == 2'h0)
        else $error("reserved posted bit set");
    a_timer_sticky: assert property (
        $fell(posted_vec[3]) |-> $past(wr_q) || $past(ack_clr[3]))
        else $error("posted bit dropped without clear");
    a_pend_cause: assert property (irq_pending |-> any_q)
        else $error("pending without posted source");
    a_soft_by_wr: assert property (
        $changed(soft_irq_enable) |-> $past(wr_q))
        else $error("soft mode changed without write");
    a_read_wait: assert property (
        take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    cover property (take && !hwrite);
    cover property ($rose(soft_irq_enable));
    cover property ($fell(irq_pending));
endmodule
bind pic_top pic_top_asserts i_chk
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .spi_evt(spi_evt), .usb_wake_evt(usb_wake_evt),
    .ack_clr(ack_clr), .irq_pending(irq_pending),
    .posted_vec(posted_vec), .soft_irq_enable(soft_irq_enable)
);

// File: testbench/pic_src_model.sv
`timescale 1ns/10ps
module pic_src_model
(
    input wire hclk,          // System clock
    input wire [23:0] fire,   // Requests, in posted-bit order
    output reg [23:0] evt = 24'h0 // Source event lines
);
    // Sources raise their line a clock after each request
    always @(posedge hclk)
    begin
        evt <= fire;
    end
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/10ps
`include "pic_map.vh"
module tb_top;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg hwrite = 1'b0;
    reg [1:0] htrans = 2'h0;
    reg [31:0] haddr = 32'h0;
    reg [31:0] hwdata = 32'h0;
    reg [23:0] fire = 24'h0;
    reg [23:0] ack_clr = 24'h0;
    reg [31:0] rd;
    wire hready, hresp, irq_pending, soft_irq_enable, evt_irq;
    wire [31:0] hrdata;
    wire [23:0] posted_vec, evt;
    integer err_count = 0;
    integer n_compared = 0;
    localparam [23:0] IMPL = {`PIC_IMPL_C, `PIC_IMPL_B, `PIC_IMPL_A};
    always #25 hclk = ~hclk;
    pic_src_model i_src (.hclk(hclk), .fire(fire), .evt(evt));
    pic_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .sbus_slave_evt(evt[7]),
        .sleep_evt(evt[6]), .spi_evt(evt[5]), .gpio_evt(evt[4]),
        .timer_zero_irq(evt[3]), .supply_mon_evt(evt[0]),
        .timer_one_irq(evt[8]), .timer_two_irq(evt[9]),
        .usb_reset_evt(evt[10]), .usb_sof_evt(evt[11]),
        .usb_ep_evt({evt[20:16], evt[15:12]}), .usb_wake_evt(evt[21]),
        .ack_clr(ack_clr), .irq_pending(irq_pending),
        .posted_vec(posted_vec), .soft_irq_enable(soft_irq_enable),
        .evt_irq(evt_irq));
    task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp)
            begin
                err_count = err_count + 1;
                $display("unexpected %0s: expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task bus(input w, input [7:0] ix, input [7:0] d);
        begin
            @(posedge hclk);
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= {22'h0, ix, 2'h0};
            @(posedge hclk);
            while (hready !== 1'b1)
                @(posedge hclk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= {24'h0, d};
            @(posedge hclk);
            while (hready !== 1'b1)
                @(posedge hclk);
            rd = hrdata;
            #1;
        end
    endtask
    task rdc(input [7:0] ix, input [31:0] exp);
        begin
            bus(1'b0, ix, 8'h00);
            chk("read", exp, rd);
        end
    endtask
    // Acknowledge lands in the same cycle as the source line
    task post(input [23:0] v, input [23:0] a);
        begin
            @(posedge hclk);
            fire <= v;
            @(posedge hclk);
            fire <= 24'h0;
            ack_clr <= a;
            @(posedge hclk);
            ack_clr <= 24'h0;
            @(posedge hclk);
            #1;
        end
    endtask
    task t_reset;
        begin
            rdc(`PIC_IDX_STATUS_A, 32'h0);
            rdc(`PIC_IDX_STATUS_C, 32'h0);
            rdc(`PIC_IDX_SOFT_CTRL, 32'h0);
            rdc(8'hE5, 32'h0); // Unmapped place reads zero
        end
    endtask
    task t_map;
        integer i;
        reg [7:0] ix;
        reg [23:0] p;
        begin
            for (i = 0; i < 24; i = i + 1)
            begin
                ix = `PIC_IDX_STATUS_A + i[7:0] / 8'h8;
                p = (24'h1 << i) & IMPL;
                post(24'h1 << i, 24'h0);
                chk("posted", {8'h0, p}, {8'h0, posted_vec});
                chk("pending", 32'h0, {31'h0, irq_pending});
                rdc(ix, {8'h0, p >> (i / 8 * 8)});
                bus(1'b1, ix, 8'h00);
                chk("cleared", 32'h0, {8'h0, posted_vec});
            end
        end
    endtask
    task t_clr;
        begin
            post(24'h000088, 24'h0);
            bus(1'b1, `PIC_IDX_STATUS_A, 8'hF1);
            rdc(`PIC_IDX_STATUS_A, 32'h80);
            bus(1'b1, `PIC_IDX_STATUS_B, 8'h00);
            chk("posted", 32'h80, {8'h0, posted_vec});
            post(24'h000008, 24'h000008);
            chk("postwin", 32'h88, {8'h0, posted_vec});
            post(24'h0, 24'h000008);
            chk("ackclr", 32'h80, {8'h0, posted_vec});
        end
    endtask
    task t_soft;
        begin
            bus(1'b1, `PIC_IDX_SOFT_CTRL, 8'h01);
            chk("soft", 32'h1, {31'h0, soft_irq_enable});
            post(24'h100000, 24'h0);
            bus(1'b1, `PIC_IDX_STATUS_C, 8'h00);
            chk("posted", 32'h100080, {8'h0, posted_vec});
            bus(1'b1, `PIC_IDX_STATUS_C, 8'h21);
            rdc(`PIC_IDX_STATUS_C, 32'h31);
            bus(1'b1, `PIC_IDX_SOFT_CTRL, 8'h00);
            chk("soft", 32'h0, {31'h0, soft_irq_enable});
        end
    endtask
    task t_mask;
        begin
            bus(1'b1, `PIC_IDX_MASK_C, 8'h20);
            @(posedge hclk);
            #1;
            chk("pending", 32'h1, {31'h0, irq_pending});
            bus(1'b1, `PIC_IDX_EVT_MASK, 8'h02);
            chk("evt_irq", 32'h1, {31'h0, evt_irq});
            bus(1'b1, `PIC_IDX_EVT_STATUS, 8'h02);
            chk("evt_irq", 32'h0, {31'h0, evt_irq});
            // Wake is already posted: a second post merges as overrun
            post(24'h200000, 24'h0);
            rdc(`PIC_IDX_EVT_STATUS, 32'h5);
            bus(1'b1, `PIC_IDX_VEC_CLR, 8'h5A);
            chk("posted", 32'h0, {8'h0, posted_vec});
            chk("pending", 32'h0, {31'h0, irq_pending});
            @(posedge hclk);
            #1;
            chk("pending", 32'h0, {31'h0, irq_pending});
        end
    endtask
    task summarize;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_map;
        t_clr;
        t_soft;
        t_mask;
        summarize;
    end
    // Run needs under 1500 clocks; this allows several times that
    initial
    begin
        #400000;
        err_count = err_count + 1;
        summarize;
    end
endmodule
